// File: src/wwdg_top.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module wwdg_top #(
  parameter int unsigned PRESCALE_CYCLES = wwdg_pkg::PRESCALE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [wwdg_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // option pins, static
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  // cpu halt instruction strobe
  input wire logic halt_exec_i,
  // device reset request
  output logic reset_pin_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // option capture

  logic hw_meta_q;
  logic hw_sync_q;
  logic halt_meta_q;
  logic halt_sync_q;
  logic hw_opt_q;
  logic halt_opt_q;

  always_ff @(posedge clk_i)
  begin
    hw_meta_q <= hw_watchdog_opt_i;
    hw_sync_q <= hw_meta_q;
    halt_meta_q <= halt_reset_option_i;
    halt_sync_q <= halt_meta_q;
  end

  // options latched while reset is held, frozen afterwards
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hw_opt_q <= hw_sync_q; // [RL15]
      halt_opt_q <= halt_sync_q; // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic ack_q;
  logic req;
  logic ctrl_hit;
  logic stat_hit;
  logic wr_en;
  wwdg_pkg::wwdg_ctrl_t wdat;
  wwdg_pkg::wwdg_ctrl_t ctrl_rd;
  wwdg_pkg::wwdg_stat_t stat_rd;
  logic [wwdg_pkg::IDX_W-1:0] idx;

  assign idx = wb_adr_i[wwdg_pkg::ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign ctrl_hit = (idx == wwdg_pkg::CTRL_IDX);
  assign stat_hit = (idx == wwdg_pkg::STAT_IDX);
  assign wr_en = req & wb_we_i & ctrl_hit & wb_sel_i[0];
  assign wdat = wb_dat_i[wwdg_pkg::ACT_BIT:0];

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  logic tick;

  wwdg_prescaler #(
    .DIV(PRESCALE_CYCLES),
    .W($clog2(PRESCALE_CYCLES))
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  ); // [RL1] [RL14] [RL15]

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic active_q;
  logic [6:0] count_q;
  logic eff_active;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_q <= wwdg_pkg::CTRL_RESET[wwdg_pkg::ACT_BIT]; // [RL5] [RL10]
    end
    else if (wr_en && wdat.active)
    begin
      active_q <= 1'b1; // [RL11]
    end
  end

  // a write reloads and wins over a tick in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= wwdg_pkg::CTRL_RESET[wwdg_pkg::TOP_BIT:0]; // [RL10]
    end
    else if (wr_en)
    begin
      count_q <= wdat.count; // [RL12] [RL13]
    end
    else if (tick)
    begin
      count_q <= count_q - wwdg_pkg::COUNT_ONE; // [RL1] [RL3]
    end
  end

  assign eff_active = active_q | hw_opt_q; // [RL8]

  ////////////////////////////////////////////////////////////////////////////
  // reset generation

  logic timeout_trig;
  logic sw_trig;
  logic halt_trig;
  logic trigger;
  logic busy;
  logic [wwdg_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
  logic [wwdg_pkg::PULSE_CNT_W-1:0] pulse_cnt_d;

  localparam logic [wwdg_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
    wwdg_pkg::PULSE_CNT_W'(wwdg_pkg::RESET_PULSE_CYCLES);
  localparam logic [wwdg_pkg::PULSE_CNT_W-1:0] PULSE_STEP =
    wwdg_pkg::PULSE_CNT_W'(1);

  assign timeout_trig = eff_active & tick & ~wr_en
    & (count_q == wwdg_pkg::COUNT_EXPIRE); // [RL2]
  assign sw_trig = wr_en & (wdat.active | eff_active)
    & ~wdat.count[wwdg_pkg::TOP_BIT]; // [RL6]
  assign halt_trig = halt_exec_i & eff_active & halt_opt_q; // [RL7]
  assign trigger = timeout_trig | sw_trig | halt_trig;
  assign busy = (pulse_cnt_q != '0);

  // a pulse in progress ignores new triggers
  always_comb
  begin
    pulse_cnt_d = pulse_cnt_q;
    if (busy)
    begin
      pulse_cnt_d = pulse_cnt_q - PULSE_STEP;
    end
    else if (trigger)
    begin
      pulse_cnt_d = PULSE_LOAD; // [RL2]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pulse_cnt_q <= '0;
    end
    else
    begin
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reset_pin_n_o <= 1'b1;
    end
    else
    begin
      reset_pin_n_o <= (pulse_cnt_d == '0); // [RL2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer

  always_comb
  begin
    ctrl_rd.active = active_q;
    ctrl_rd.count = count_q;
    stat_rd = '0;
    stat_rd.eff_active = eff_active;
    stat_rd.pulse_busy = busy;
    stat_rd.hw_opt = hw_opt_q;
    stat_rd.halt_opt = halt_opt_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= '0;
    end
    else if (req && !wb_we_i)
    begin
      if (ctrl_hit)
      begin
        wb_dat_o <= {wwdg_pkg::UPPER_ZERO, ctrl_rd}; // [RL10] [RL12]
      end
      else if (stat_hit)
      begin
        wb_dat_o <= {wwdg_pkg::UPPER_ZERO, stat_rd};
      end
      else
      begin
        wb_dat_o <= '0;
      end
    end
  end

  assign wb_ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_tick_decrement: // [RL1]
    assert property (tick && !wr_en |=> count_q == $past(count_q) - wwdg_pkg::COUNT_ONE)
    else $error("count did not step down on tick");

  a_count_holds: // [RL1]
    assert property (!tick && !wr_en |=> $stable(count_q))
    else $error("count moved without a tick");

  a_free_running: // [RL3]
    assert property (!eff_active && tick && !wr_en |=> count_q != $past(count_q))
    else $error("count stalled while inactive");

  a_timeout_pulse: // [RL2]
    assert property (eff_active && tick && !wr_en && count_q == wwdg_pkg::COUNT_EXPIRE
      && !busy |=> busy ##1 !reset_pin_n_o)
    else $error("expiry did not start a reset pulse");

  a_pulse_length: // [RL2]
    assert property ($fell(busy) |-> $past(pulse_cnt_q) == PULSE_STEP
      && !$past(reset_pin_n_o) && reset_pin_n_o)
    else $error("reset pulse ended wrongly");

  a_pulse_load: // [RL2]
    assert property ($rose(busy) |-> pulse_cnt_q == PULSE_LOAD)
    else $error("reset pulse length wrong");

  a_active_sticky: // [RL5]
    assert property (active_q |=> active_q)
    else $error("activation cleared without reset");

  a_active_set: // [RL11]
    assert property (wr_en && wdat.active |=> active_q)
    else $error("activation write ignored");

  a_sw_reset: // [RL6]
    assert property (wr_en && wdat.active && !wdat.count[wwdg_pkg::TOP_BIT] && !busy
      |=> busy)
    else $error("software reset request lost");

  a_halt_reset: // [RL7]
    assert property (halt_exec_i && eff_active && halt_opt_q && !busy |=> busy)
    else $error("halt did not reset");

  a_halt_quiet: // [RL7]
    assert property (halt_exec_i && !halt_opt_q && !busy && !timeout_trig && !sw_trig
      |=> !busy)
    else $error("halt reset despite option");

  a_hw_active: // [RL8]
    assert property (hw_opt_q |-> eff_active)
    else $error("hardware option not active");

  a_reload: // [RL12]
    assert property (wr_en |=> count_q == $past(wdat.count))
    else $error("write did not reload count");

  a_read_ctrl: // [RL10]
    assert property (req && !wb_we_i && ctrl_hit |=> wb_ack_o
      && wb_dat_o[7:0] == $past({active_q, count_q}))
    else $error("control read data wrong");

endmodule // wwdg_top

// File: src/wwdg_pkg.sv
// Functional notes
// RL1 - count decrements once per 16000 machine cycles
// RL2 - active and 40h to 3Fh: pulse reset low
// RL3 - counter keeps running while watchdog inactive
// RL4 - software reloads periodically with C0h to FFh
// RL5 - inactive after reset; only reset deactivates
// RL6 - write activation set, top clear: immediate reset
// RL7 - halt while active resets unless option suppresses; the code resets on halt only while the halt option is set
// RL8 - hardware option: always active, activation bit ignored
// RL9 - with halt option, reload just before halting
// RL10 - control register read/write, resets to 7Fh
// RL11 - activation bit 7: software sets, reset clears
// RL12 - bits 6:0 read count, write reloads it
// RL13 - timeout programmable in 64 prescaled steps
// RL14 - timeout spread from unknown prescaler phase
// RL15 - options sampled at reset; prescaler cleared by reset
package wwdg_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RESET_PULSE_NS = 30000;
  localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W = 10;
  localparam int unsigned PRESCALE_CYCLES = 16000;

  // register map: offsets are word indices, byte address = 4 * index
  localparam int unsigned ADR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h2e;
  localparam logic [IDX_W-1:0] STAT_IDX = 6'h2f;

  // control register layout and values
  localparam int unsigned ACT_BIT = 7;
  localparam int unsigned TOP_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam logic [6:0] COUNT_EXPIRE = 7'h40;
  localparam logic [6:0] COUNT_ONE = 7'h01;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;

  typedef struct packed {
    logic active;
    logic [6:0] count;
  } wwdg_ctrl_t;

  typedef struct packed {
    logic [3:0] spare;
    logic halt_opt;
    logic hw_opt;
    logic pulse_busy;
    logic eff_active;
  } wwdg_stat_t;

endpackage

// File: src/wwdg_prescaler.sv
`timescale 1ns/1ns
// free-running divider, one tick every DIV clocks; only reset clears it
module wwdg_prescaler #(
  parameter int unsigned DIV = wwdg_pkg::PRESCALE_CYCLES,
  parameter int unsigned W = $clog2(DIV)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick out
  output logic tick_o
);

  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] STEP = W'(1);

  logic [W-1:0] div_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
    end
    else if (div_q == LAST)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + STEP;
    end
  end

  assign tick_o = (div_q == LAST);

endmodule // wwdg_prescaler

// File: tb/wwdg_top_bench.sv
`timescale 1ns/1ns
module wwdg_top_bench;
  localparam int unsigned PS = 8;
  localparam logic [7:0] CTRL_A = 8'hb8;
  localparam logic [7:0] STAT_A = 8'hbc;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic hw_opt = 1'b0;
  logic halt_opt = 1'b0;
  logic halt_exec = 1'b0;
  logic reset_pin_n_o;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  int c;
  int unsigned r;
  int cyc_n = 0;
  int fell_at = 0;
  logic pin_q = 1'b1;

  wwdg_top #(.PRESCALE_CYCLES(PS)) wwdg_top_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .hw_watchdog_opt_i(hw_opt),
    .halt_reset_option_i(halt_opt),
    .halt_exec_i(halt_exec),
    .reset_pin_n_o(reset_pin_n_o)
  );

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // stamps the cycle after the edge that pulls the reset pin low
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    pin_q <= reset_pin_n_o;
    if (reset_pin_n_o === 1'b0 && pin_q === 1'b1)
      fell_at <= cyc_n;
  end

  // earliest expiry after a reload, in clocks: one prescaled step per count above 40h
  function automatic int expiry_lo(input logic [7:0] w);
    return PS * int'(w[5:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, s, e);
    end
  endtask

  task automatic do_reset(input logic hw, input logic ht);
    @(posedge clk_i);
    rst_i <= 1'b1;
    hw_opt <= hw;
    halt_opt <= ht;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // one classic cycle; entered just after an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // cycles the reset pin stays at level lv, capped at mx
  task automatic span(input logic lv, input int mx, output int n);
    n = 0;
    while (reset_pin_n_o === lv && n < mx)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic pulse(input int mx);
    int n;
    span(1'b1, mx, n);
    chk(n < mx, 1'b1);
    span(1'b0, 700, n);
    chk(cyc_n - fell_at, wwdg_pkg::RESET_PULSE_CYCLES);
  endtask

  // reload, read back, then expect expiry within one prescaled step of the window
  task automatic tmo(input logic [7:0] w);
    int t0;
    int d;
    wb(1'b1, CTRL_A, w);
    t0 = cyc_n;
    wb(1'b0, CTRL_A, 8'h00);
    chk(rd[7:0] === w || rd[7:0] === w - 8'h01, 1'b1);
    pulse(expiry_lo(w) + PS + 20);
    d = fell_at - t0;
    chk(d >= expiry_lo(w) && d < expiry_lo(w) + PS, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(50 * 40000);
    miscompares++;
    stop_test();
  end

  initial
  begin
    r = $urandom(32'h0bd6);
    do_reset(1'b0, 1'b1);
    wb(1'b0, CTRL_A, 8'h00);
    chk(rd, 32'h0000007f);
    wb(1'b0, STAT_A, 8'h00);
    chk(rd, 32'h00000008);
    wb(1'b1, STAT_A, 8'hff);
    wb(1'b0, STAT_A, 8'h00);
    chk(rd, 32'h00000008);
    wb(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h00000000);
    $display("test registers done");
    wb(1'b1, CTRL_A, 8'h41);
    span(1'b1, 40, c);
    chk(c, 40);
    wb(1'b0, CTRL_A, 8'h00);
    chk(rd[7:6], 2'b00);
    $display("test free running done");
    wb(1'b1, CTRL_A, 8'hff);
    wb(1'b1, CTRL_A, 8'h7f);
    wb(1'b0, CTRL_A, 8'h00);
    chk(rd[7], 1'b1);
    halt_exec <= 1'b1;
    @(posedge clk_i);
    halt_exec <= 1'b0;
    pulse(4);
    do_reset(1'b0, 1'b0);
    wb(1'b0, CTRL_A, 8'h00);
    chk(rd[7], 1'b0);
    wb(1'b1, CTRL_A, 8'hff);
    halt_exec <= 1'b1;
    @(posedge clk_i);
    halt_exec <= 1'b0;
    span(1'b1, 20, c);
    chk(c, 20);
    $display("test lock and halt done");
    do_reset(1'b0, 1'b0);
    wb(1'b1, CTRL_A, 8'h80);
    pulse(2);
    do_reset(1'b1, 1'b0);
    wb(1'b0, STAT_A, 8'h00);
    chk(rd, 32'h00000005);
    tmo(8'h41);
    $display("test software and option reset done");
    do_reset(1'b0, 1'b0);
    tmo(8'hc0);
    repeat (4)
    begin
      do_reset(1'b0, 1'b0);
      r = $urandom % 8;
      tmo(8'hc0 | r[7:0]);
    end
    $display("test timeouts done");
    stop_test();
  end
endmodule // wwdg_top_bench
